// ---- logic/alu_map.vh ----
// operation codes, flag positions and reset values for the arithmetic/logic/shift unit
// assumes the includer owns the ports; definitions only
`ifndef ALU_MAP_VH
`define ALU_MAP_VH
// operation select codes (5 bits)
`define OP_ADD            5'h00
`define OP_SUB            5'h01
`define OP_ADD_WITH_CARRY 5'h02
`define OP_SUB_WITH_BORROW 5'h03
`define OP_INC            5'h04
`define OP_DEC            5'h05
`define OP_WORD_ADD_SMALL 5'h06
`define OP_WORD_SUB_SMALL 5'h07
`define OP_DEC_ADJ_ADD    5'h08
`define OP_DEC_ADJ_SUB    5'h09
`define OP_UNSIGNED_MUL   5'h0A
`define OP_UNSIGNED_DIV   5'h0B
`define OP_COMPARE        5'h0C
`define OP_TWOS_COMP      5'h0D
`define OP_AND            5'h0E
`define OP_OR             5'h0F
`define OP_XOR            5'h10
`define OP_NOT            5'h11
`define OP_ASHL           5'h12
`define OP_ASHR           5'h13
`define OP_LSHL           5'h14
`define OP_LSHR           5'h15
`define OP_ROTATE_LEFT           5'h16
`define OP_ROTATE_RIGHT           5'h17
`define OP_ROTCL          5'h18
`define OP_ROTCR          5'h19
// flag vector positions: {h, n, z, v, c}
`define FLAG_C            0
`define FLAG_V            1
`define FLAG_Z            2
`define FLAG_N            3
`define FLAG_H            4
`define FLAGS_RESET       5'h00
`define RESULT_RESET      16'h0000
// divider iterations, one quotient bit per cycle
`define DIV_STEPS         4'h8
`endif

// ---- logic/shift_unit.v ----
// byte shift and rotate network, purely combinational
// assumes the caller supplies a shift-class op code and the current carry
`default_nettype none
`include "alu_map.vh"
module shift_unit (
  input  wire [4:0] op,
  input  wire [7:0] din,
  input  wire       cin,
  output reg  [7:0] dout,
  output reg        cout,
  output reg        vout
);
  // every shift moves exactly one place; the outgoing bit goes to carry
  always @* begin
    dout = din;
    cout = 1'b0;
    vout = 1'b0;
    case (op)
      `OP_ASHL: begin
        dout = {din[6:0], 1'b0};
        cout = din[7];
        vout = din[7] ^ din[6];   // sign change marks overflow
      end
      `OP_ASHR: begin
        dout = {din[7], din[7:1]}; // sign kept
        cout = din[0];
      end
      `OP_LSHL: begin
        dout = {din[6:0], 1'b0};
        cout = din[7];
      end
      `OP_LSHR: begin
        dout = {1'b0, din[7:1]};
        cout = din[0];
      end
      `OP_ROTATE_LEFT: begin
        dout = {din[6:0], din[7]};
        cout = din[7];
      end
      `OP_ROTATE_RIGHT: begin
        dout = {din[0], din[7:1]};
        cout = din[0];
      end
      `OP_ROTCL: begin
        dout = {din[6:0], cin};   // nine-bit ring
        cout = din[7];
      end
      `OP_ROTCR: begin
        dout = {cin, din[7:1]};
        cout = din[0];
      end
      default: begin
        dout = din;
      end
    endcase
  end
endmodule // shift_unit
`default_nettype wire

// ---- logic/divide_unit.v ----
// sequential 16/8 unsigned restoring divider, one quotient bit per clock
// assumes start is a one-cycle pulse and operands hold only at start
`default_nettype none
`include "alu_map.vh"
module divide_unit (
  input  wire        clk,
  input  wire        nrst,
  input  wire        start,
  input  wire [15:0] dividend,
  input  wire [7:0]  divisor,
  output reg         done_q,
  output reg  [7:0]  quot_q,
  output reg  [7:0]  rem_q
);
  reg  [8:0]  part_q;
  reg  [7:0]  low_q;
  reg  [7:0]  dsr_q;
  reg  [3:0]  cnt_q;
  reg         busy_q;
  wire [8:0]  trial;
  wire        fits;

  // shift in the next dividend bit, subtract if it fits
  assign trial = {part_q[7:0], low_q[7]};
  assign fits  = trial >= {1'b0, dsr_q};

  ////////////////////////////////////////////////////////////////////////
  // iteration; a zero divisor yields all-ones quotient, no trap here
  always @(posedge clk) begin
    if (!nrst) begin
      part_q <= 9'h000;
      low_q  <= 8'h00;
      dsr_q  <= 8'h00;
      cnt_q  <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      quot_q <= 8'h00;
      rem_q  <= 8'h00;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        part_q <= {1'b0, dividend[15:8]};
        low_q  <= dividend[7:0];
        dsr_q  <= divisor;
        cnt_q  <= `DIV_STEPS;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        part_q <= fits ? (trial - {1'b0, dsr_q}) : trial;
        low_q  <= {low_q[6:0], fits}; // quotient bits collect in low_q
        cnt_q  <= cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          quot_q <= {low_q[6:0], fits};
          rem_q  <= fits ? (trial[7:0] - dsr_q) : trial[7:0];
        end
      end
    end
  end
endmodule // divide_unit
`default_nettype wire

// ---- logic/arith_logic_shift_unit.v ----
// cpu execution datapath: arithmetic, logic, shift/rotate with flag update
// assumes the decoder presents op, operands and flags on a one-cycle issue pulse
`default_nettype none
`include "alu_map.vh"
// Behaviour
// - add or subtract registers byte or word; add immediate; write destination.
// - plain subtract accepts register second operand only, never immediate.
// - word add and subtract only between two registers.
// - carry add and subtract are byte only, using carry in; register or immediate.
// - increment and decrement change a byte register by exactly one.
// - word adjust adds or subtracts one or two on a 16-bit register.
// - decimal adjust corrects a byte sum or difference using flags.
// - unsigned 8x8 multiply gives a 16-bit destination result.
// - 16/8 unsigned divide gives 8-bit quotient and remainder in destination.
// - compare subtracts without writeback, updating only flags.
// - word compare between registers only; immediate compare is byte.
// - negate replaces byte with zero minus its value.
// - AND, OR, XOR combine byte destination with register or immediate.
// - complement inverts every bit of a byte register.
// - arithmetic shifts move a byte one place left or right.
// - logical shifts move one place, vacated bit zero.
// - plain rotates feed the outgoing bit into the opposite end.
// - carry rotates treat byte plus carry as a nine-bit ring.
// - flags negative, zero, overflow, carry updated by ops, carry read.
module arith_logic_shift_unit (
  input  wire        clk,
  input  wire        nrst,
  input  wire        issue,
  input  wire [4:0]  op,
  input  wire        word_size,
  input  wire        use_imm,
  input  wire [15:0] dest_register,
  input  wire [15:0] source_register,
  input  wire [7:0]  imm_data,
  input  wire [4:0]  flags_in,
  output reg         done_q,
  output reg         write_q,
  output reg         illegal_q,
  output reg  [15:0] result_q,
  output reg  [4:0]  flags_q
);
  reg  [15:0] res_d;
  reg  [4:0]  flg_d;
  reg         wr_d;
  reg         ill_d;
  reg         fin_d;
  reg         arith;
  reg         is_sub;
  reg         cy_in;
  reg  [15:0] opa;
  reg  [15:0] opb;
  reg  [16:0] sum;
  reg  [4:0]  low_sum;
  reg  [7:0]  adj;
  reg         adj_c;
  reg         div_pend_q;
  wire [7:0]  shf_out;
  wire        shf_c;
  wire        shf_v;
  wire        div_done;
  wire [7:0]  div_quot;
  wire [7:0]  div_rem;
  wire        div_start;
  wire [7:0]  src_b;
  wire        cin;
  wire        hin;
  wire        shift_op;

  assign cin      = flags_in[`FLAG_C];
  assign hin      = flags_in[`FLAG_H];
  assign src_b    = use_imm ? imm_data : source_register[7:0];
  assign shift_op = (op >= `OP_ASHL) && (op <= `OP_ROTCR);
  // divide runs several cycles; other ops finish in one
  assign div_start = issue && (op == `OP_UNSIGNED_DIV);

  ////////////////////////////////////////////////////////////////////////
  shift_unit u_shift (
    .op   (op),
    .din  (dest_register[7:0]),
    .cin  (cin),
    .dout (shf_out),
    .cout (shf_c),
    .vout (shf_v)
  );

  divide_unit u_div (
    .clk      (clk),
    .nrst     (nrst),
    .start    (div_start),
    .dividend (dest_register),
    .divisor  (source_register[7:0]),
    .done_q   (div_done),
    .quot_q   (div_quot),
    .rem_q    (div_rem)
  );

  ////////////////////////////////////////////////////////////////////////
  // operand selection for the shared adder
  always @* begin
    arith  = 1'b0;
    is_sub = 1'b0;
    cy_in  = 1'b0;
    opa    = dest_register;
    opb    = 16'h0000;
    ill_d  = 1'b0;
    case (op)
      `OP_ADD: begin
        arith = 1'b1;
        opb   = use_imm ? {8'h00, imm_data} : source_register;
        ill_d = use_imm && word_size;
      end
      `OP_SUB: begin
        arith  = 1'b1;
        is_sub = 1'b1;
        opb    = source_register;
        ill_d  = use_imm;
      end
      `OP_ADD_WITH_CARRY: begin
        arith = 1'b1;
        opb   = {8'h00, src_b};
        cy_in = cin;
        ill_d = word_size;
      end
      `OP_SUB_WITH_BORROW: begin
        arith  = 1'b1;
        is_sub = 1'b1;
        opb    = {8'h00, src_b};
        cy_in  = cin;
        ill_d  = word_size;
      end
      `OP_INC: begin
        arith = 1'b1;
        opb   = 16'h0001;
      end
      `OP_DEC: begin
        arith  = 1'b1;
        is_sub = 1'b1;
        opb    = 16'h0001;
      end
      `OP_WORD_ADD_SMALL: begin
        opb = source_register[1] ? 16'h0002 : 16'h0001;
      end
      `OP_WORD_SUB_SMALL: begin
        is_sub = 1'b1;
        opb    = source_register[1] ? 16'h0002 : 16'h0001;
      end
      `OP_COMPARE: begin
        arith  = 1'b1;
        is_sub = 1'b1;
        opb    = use_imm ? {8'h00, imm_data} : source_register;
        ill_d  = use_imm && word_size;
      end
      `OP_TWOS_COMP: begin
        arith  = 1'b1;
        is_sub = 1'b1;
        opa    = 16'h0000;
        opb    = {8'h00, dest_register[7:0]};
      end
      default: begin
        opb = {8'h00, src_b};
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // adder, byte decimal correction, and result/flag assembly
  always @* begin
    sum     = is_sub ? ({1'b0, opa} - {1'b0, opb} - {16'h0000, cy_in})
                     : ({1'b0, opa} + {1'b0, opb} + {16'h0000, cy_in});
    low_sum = is_sub ? ({1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cy_in})
                     : ({1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cy_in});
    adj   = 8'h00;
    adj_c = cin;
    // six per nibble, chosen by carry, half-carry and, for add only, digit range
    if (op == `OP_DEC_ADJ_ADD) begin
      if (hin || (dest_register[3:0] > 4'h9)) begin
        adj = adj | 8'h06;
      end
      if (cin || (dest_register[7:0] > 8'h99)) begin
        adj   = adj | 8'h60;
        adj_c = 1'b1;
      end
    end else begin
      if (hin) begin
        adj = adj | 8'h06;
      end
      if (cin) begin
        adj = adj | 8'h60;
      end
    end
    res_d = dest_register;
    flg_d = flags_in;
    wr_d  = 1'b1;
    fin_d = 1'b1;
    if (arith) begin
      res_d = word_size ? sum[15:0] : {dest_register[15:8], sum[7:0]};
      // flags follow the operand width
      if (word_size) begin
        flg_d[`FLAG_N] = sum[15];
        flg_d[`FLAG_Z] = (sum[15:0] == 16'h0000);
        flg_d[`FLAG_C] = sum[16];
        flg_d[`FLAG_V] = is_sub ? ((opa[15] ^ opb[15]) & (opa[15] ^ sum[15]))
                                : (~(opa[15] ^ opb[15]) & (opa[15] ^ sum[15]));
      end else begin
        flg_d[`FLAG_N] = sum[7];
        flg_d[`FLAG_Z] = (sum[7:0] == 8'h00);
        // nine-bit compare so an ff operand plus borrow-in cannot wrap
        flg_d[`FLAG_C] = is_sub ? ({1'b0, opa[7:0]} < ({1'b0, opb[7:0]} + {8'h00, cy_in}))
                                : (({1'b0, opa[7:0]} + {1'b0, opb[7:0]}
                                    + {8'h00, cy_in}) > 9'h0FF);
        flg_d[`FLAG_V] = is_sub ? ((opa[7] ^ opb[7]) & (opa[7] ^ sum[7]))
                                : (~(opa[7] ^ opb[7]) & (opa[7] ^ sum[7]));
        flg_d[`FLAG_H] = low_sum[4];
        // carry ops keep zero sticky across a byte chain
        if ((op == `OP_ADD_WITH_CARRY) || (op == `OP_SUB_WITH_BORROW)) begin
          flg_d[`FLAG_Z] = flags_in[`FLAG_Z] & (sum[7:0] == 8'h00);
        end
        // inc/dec leave carry alone
        if ((op == `OP_INC) || (op == `OP_DEC)) begin
          flg_d[`FLAG_C] = cin;
        end
      end
      if (op == `OP_COMPARE) begin
        res_d = dest_register;
        wr_d  = 1'b0;
      end
    end else if ((op == `OP_WORD_ADD_SMALL) || (op == `OP_WORD_SUB_SMALL)) begin
      res_d = sum[15:0];                                         // flags untouched
    end else if ((op == `OP_DEC_ADJ_ADD) || (op == `OP_DEC_ADJ_SUB)) begin
      res_d[7:0] = (op == `OP_DEC_ADJ_ADD) ? (dest_register[7:0] + adj)
                                          : (dest_register[7:0] - adj);
      flg_d[`FLAG_N] = res_d[7];
      flg_d[`FLAG_Z] = (res_d[7:0] == 8'h00);
      flg_d[`FLAG_C] = adj_c;
    end else if (op == `OP_UNSIGNED_MUL) begin
      res_d = {8'h00, dest_register[7:0]} * {8'h00, source_register[7:0]};
    end else if (op == `OP_UNSIGNED_DIV) begin
      wr_d  = 1'b0;
      fin_d = 1'b0;
    end else if ((op >= `OP_AND) && (op <= `OP_NOT)) begin
      case (op)
        `OP_AND: res_d[7:0] = dest_register[7:0] & src_b;
        `OP_OR:  res_d[7:0] = dest_register[7:0] | src_b;
        `OP_XOR: res_d[7:0] = dest_register[7:0] ^ src_b;
        default: res_d[7:0] = ~dest_register[7:0];
      endcase
      flg_d[`FLAG_N] = res_d[7];
      flg_d[`FLAG_Z] = (res_d[7:0] == 8'h00);
      flg_d[`FLAG_V] = 1'b0;
    end else if (shift_op) begin
      res_d[7:0]     = shf_out;
      flg_d[`FLAG_N] = shf_out[7];
      flg_d[`FLAG_Z] = (shf_out == 8'h00);
      flg_d[`FLAG_V] = shf_v;
      flg_d[`FLAG_C] = shf_c;
    end else begin
      wr_d = 1'b0;
    end
    // refused forms leave registers and flags as they were
    if (ill_d) begin
      res_d = dest_register;
      flg_d = flags_in;
      wr_d  = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs; divide answers the cycle after its last iteration
  always @(posedge clk) begin
    if (!nrst) begin
      done_q     <= 1'b0;
      write_q    <= 1'b0;
      illegal_q  <= 1'b0;
      result_q   <= `RESULT_RESET;
      flags_q    <= `FLAGS_RESET;
      div_pend_q <= 1'b0;
    end else begin
      done_q    <= 1'b0;
      write_q   <= 1'b0;
      illegal_q <= 1'b0;
      if (div_start) begin
        div_pend_q <= 1'b1;
        flags_q    <= flags_in;
      end else if (issue) begin
        done_q    <= fin_d;
        write_q   <= wr_d;
        illegal_q <= ill_d;
        result_q  <= res_d;
        flags_q   <= flg_d;
      end else if (div_done && div_pend_q) begin
        div_pend_q <= 1'b0;
        done_q     <= 1'b1;
        write_q    <= 1'b1;
        result_q   <= {div_rem, div_quot};
      end
    end
  end
endmodule // arith_logic_shift_unit
`default_nettype wire

// ---- dv/alu_checker_assertions.sv ----
// concurrent checks on the ports of the arithmetic/logic/shift unit
// assumes alu_map.vh op codes, one clock and a synchronous active-low reset
`default_nettype none
`include "alu_map.vh"
module alu_checker (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        issue,
  input wire logic [4:0]  op,
  input wire logic        word_size,
  input wire logic        use_imm,
  input wire logic [15:0] dest_register,
  input wire logic [15:0] source_register,
  input wire logic [7:0]  imm_data,
  input wire logic [4:0]  flags_in,
  input wire logic        done_q,
  input wire logic        write_q,
  input wire logic        illegal_q,
  input wire logic [15:0] result_q,
  input wire logic [4:0]  flags_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////////////////////////
  // answer timing
  a_quick_answer: assert property (issue && op != `OP_UNSIGNED_DIV |=> done_q)
    else $error("single-cycle op gave no answer");
  // divider: nine quiet cycles, then the written answer
  a_div_latency: assert property (issue && op == `OP_UNSIGNED_DIV
    |=> !done_q [*8] ##1 !done_q ##1 (done_q && write_q))
    else $error("divide answer at wrong cycle");
  // result holds between answers, so the register file may sample late
  a_result_holds: assert property (!done_q |-> $stable(result_q))
    else $error("result moved without an answer");
  //////////////////////////////////////////////////////////////////////
  // refused forms are flagged and not written, immediate subtract also keeps result and flags; compare writes nothing back
  a_refuse_subimm: assert property (issue && op == `OP_SUB && use_imm
    |=> illegal_q && !write_q && result_q == $past(dest_register) && flags_q == $past(flags_in))
    else $error("immediate subtract not refused");
  a_refuse_wordimm: assert property (issue && use_imm && word_size
    && (op == `OP_ADD || op == `OP_COMPARE) |=> illegal_q && !write_q)
    else $error("word immediate form not refused");
  a_carry_byte: assert property (issue && word_size
    && (op == `OP_ADD_WITH_CARRY || op == `OP_SUB_WITH_BORROW) |=> illegal_q && !write_q)
    else $error("word carry op not refused");
  a_cmp_nowrite: assert property (issue && op == `OP_COMPARE |=> !write_q)
    else $error("compare wrote its difference");
  //////////////////////////////////////////////////////////////////////
  // value relations; the increment and multiply masks keep only the low byte in view
  a_inc_step: assert property (issue && op == `OP_INC
    |=> ((result_q - $past(dest_register)) & 16'h00FF) == 16'h0001)
    else $error("increment not by one");
  a_word_adjust: assert property (issue && op == `OP_WORD_ADD_SMALL
    |=> result_q - $past(dest_register)
        == ((($past(source_register) >> 1) & 16'h0001) + 16'h0001))
    else $error("word adjust constant wrong");
  a_mul_product: assert property (issue && op == `OP_UNSIGNED_MUL
    |=> result_q == ($past(dest_register) & 16'h00FF) * ($past(source_register) & 16'h00FF))
    else $error("product wrong");
  a_not_inverts: assert property (issue && op == `OP_NOT
    |=> (result_q ^ $past(dest_register)) == 16'h00FF)
    else $error("complement wrong");
  // main scenarios reached
  c_divide: cover property (issue && op == `OP_UNSIGNED_DIV ##10 done_q);
  c_refused: cover property (done_q && illegal_q);
  c_carry_out: cover property (done_q && write_q && flags_q[`FLAG_C]);
endmodule // alu_checker

bind arith_logic_shift_unit alu_checker u_alu_checker (
  .clk(clk), .nrst(nrst), .issue(issue), .op(op), .word_size(word_size),
  .use_imm(use_imm), .dest_register(dest_register), .source_register(source_register),
  .imm_data(imm_data), .flags_in(flags_in), .done_q(done_q), .write_q(write_q),
  .illegal_q(illegal_q), .result_q(result_q), .flags_q(flags_q));
`default_nettype wire

// ---- dv/write_sink.sv ----
// register file side: takes each written result and counts the writes
// assumes done_q and write_q are one-cycle pulses beside a held result
`default_nettype none
module write_sink (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        done_q,
  input wire logic        write_q,
  input wire logic [15:0] result_q,
  output logic     [15:0] last_q,
  output logic     [7:0]  cnt_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // write back only on a written answer; compare and refusals leave it alone
  always @(posedge clk) begin
    if (!nrst) begin
      last_q <= 16'h0000;
      cnt_q  <= 8'h00;
    end else if (done_q && write_q) begin
      last_q <= result_q;
      cnt_q  <= cnt_q + 8'h01;
    end
  end
endmodule // write_sink
`default_nettype wire

// ---- dv/arith_logic_shift_unit_tb.sv ----
// directed testbench: one or more issues per op, answer and write-back compared
// assumes alu_map.vh op codes and flag order {h, n, z, v, c}
`default_nettype none
`include "alu_map.vh"
module arith_logic_shift_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, nrst = 1'b0, issue = 1'b0, word_size = 1'b0, use_imm = 1'b0;
  logic [4:0]  op = 5'h00, flags_in = 5'h00, flags_q;
  logic [15:0] dest_register = 16'h0000, source_register = 16'h0000, result_q, last_q;
  logic [7:0]  imm_data = 8'h00, cnt_q;
  logic        done_q, write_q, illegal_q;
  int          num_errors = 0, tests_run = 0;
  arith_logic_shift_unit u_arith_logic_shift_unit (.clk(clk), .nrst(nrst), .issue(issue),
    .op(op), .word_size(word_size), .use_imm(use_imm), .dest_register(dest_register),
    .source_register(source_register), .imm_data(imm_data), .flags_in(flags_in),
    .done_q(done_q), .write_q(write_q), .illegal_q(illegal_q), .result_q(result_q),
    .flags_q(flags_q));
  write_sink u_write_sink (.clk(clk), .nrst(nrst), .done_q(done_q), .write_q(write_q),
    .result_q(result_q), .last_q(last_q), .cnt_q(cnt_q));
  // 250 MHz
  initial begin
    forever #2 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////
  task close_out;
    $display("mismatches %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    tests_run = tests_run + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one issue, bounded wait for done, then outputs and write-back
  task go(input logic [4:0] o, input logic w, input logic u, input logic [15:0] d,
          input logic [15:0] s, input logic [7:0] i, input logic [4:0] f,
          input logic [15:0] r, input logic ew, input logic el,
          input logic [4:0] ef, input logic [4:0] m);
    int n;
    logic [7:0] c0;
    n = 0;
    c0 = cnt_q;
    @(posedge clk);
    issue <= 1'b1; op <= o; word_size <= w; use_imm <= u;
    dest_register <= d; source_register <= s; imm_data <= i; flags_in <= f;
    @(posedge clk);
    issue <= 1'b0;
    #1;
    while (done_q !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
    if (n == 20) begin
      num_errors = num_errors + 1;
      close_out();
    end
    chk({15'h0000, write_q}, {15'h0000, ew});
    chk({15'h0000, illegal_q}, {15'h0000, el});
    if (ew || el) chk(result_q, r);
    chk({11'h000, flags_q & m}, {11'h000, ef & m});
    @(posedge clk);
    #1;
    chk({8'h00, cnt_q - c0}, {15'h0000, ew});
    if (ew) chk(last_q, r);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    go(`OP_ADD, 0, 0, 16'h00F0, 16'h0020, 8'h00, 5'h00, 16'h0010, 1, 0, 5'h01, 5'h0F);
    go(`OP_ADD, 1, 0, 16'h7FFF, 16'h0001, 8'h00, 5'h00, 16'h8000, 1, 0, 5'h0A, 5'h0F);
    go(`OP_ADD, 0, 1, 16'h12FF, 16'h0000, 8'h01, 5'h00, 16'h1200, 1, 0, 5'h05, 5'h0F);
    go(`OP_SUB, 0, 0, 16'h0010, 16'h0020, 8'h00, 5'h00, 16'h00F0, 1, 0, 5'h09, 5'h0F);
    go(`OP_SUB, 1, 0, 16'h1000, 16'h0001, 8'h00, 5'h00, 16'h0FFF, 1, 0, 5'h00, 5'h0F);
    go(`OP_SUB, 0, 1, 16'hABCD, 16'h0000, 8'h01, 5'h15, 16'hABCD, 0, 1, 5'h15, 5'h1F);
    go(`OP_ADD, 1, 1, 16'h1234, 16'h0000, 8'h01, 5'h0A, 16'h1234, 0, 1, 5'h0A, 5'h1F);
    go(`OP_ADD_WITH_CARRY, 1, 0, 16'h0011, 16'h0001, 8'h00, 5'h01, 16'h0011, 0, 1, 5'h01, 5'h1F);
    go(`OP_ADD_WITH_CARRY, 0, 1, 16'h0010, 16'h0000, 8'h20, 5'h01, 16'h0031, 1, 0, 5'h00, 5'h0B);
    go(`OP_SUB_WITH_BORROW, 0, 0, 16'h0010, 16'h0010, 8'h00, 5'h01, 16'h00FF, 1, 0, 5'h09, 5'h0B);
    go(`OP_SUB_WITH_BORROW, 0, 0, 16'h0000, 16'h00FF, 8'h00, 5'h01, 16'h0000, 1, 0, 5'h01, 5'h0B);
    go(`OP_INC, 0, 0, 16'h007F, 16'h0000, 8'h00, 5'h01, 16'h0080, 1, 0, 5'h0B, 5'h0F);
    go(`OP_DEC, 0, 0, 16'h3400, 16'h0000, 8'h00, 5'h00, 16'h34FF, 1, 0, 5'h08, 5'h0F);
    go(`OP_WORD_ADD_SMALL, 0, 0, 16'hFFFF, 16'h0002, 8'h00, 5'h05, 16'h0001, 1, 0, 5'h05, 5'h1F);
    go(`OP_WORD_SUB_SMALL, 0, 0, 16'h0000, 16'h0000, 8'h00, 5'h00, 16'hFFFF, 1, 0, 5'h00, 5'h1F);
    go(`OP_DEC_ADJ_ADD, 0, 0, 16'h0012, 16'h0000, 8'h00, 5'h10, 16'h0018, 1, 0, 5'h00, 5'h01);
    go(`OP_DEC_ADJ_ADD, 0, 0, 16'h009A, 16'h0000, 8'h00, 5'h00, 16'h0000, 1, 0, 5'h01, 5'h01);
    go(`OP_DEC_ADJ_SUB, 0, 0, 16'h000F, 16'h0000, 8'h00, 5'h10, 16'h0009, 1, 0, 5'h00, 5'h01);
    go(`OP_DEC_ADJ_SUB, 0, 0, 16'h00F0, 16'h0000, 8'h00, 5'h01, 16'h0090, 1, 0, 5'h01, 5'h01);
    go(`OP_UNSIGNED_MUL, 0, 0, 16'h77FF, 16'h55FF, 8'h00, 5'h00, 16'hFE01, 1, 0, 5'h00, 5'h1F);
    go(`OP_UNSIGNED_DIV, 0, 0, 16'h1234, 16'h0056, 8'h00, 5'h00, 16'h1036, 1, 0, 5'h00, 5'h1F);
    go(`OP_COMPARE, 0, 1, 16'h0005, 16'h0000, 8'h05, 5'h00, 16'h0000, 0, 0, 5'h04, 5'h0F);
    go(`OP_COMPARE, 1, 0, 16'h1234, 16'h1235, 8'h00, 5'h00, 16'h0000, 0, 0, 5'h09, 5'h0F);
    go(`OP_COMPARE, 1, 1, 16'h1234, 16'h0000, 8'h34, 5'h02, 16'h1234, 0, 1, 5'h02, 5'h1F);
    go(`OP_TWOS_COMP, 0, 0, 16'h0001, 16'h0000, 8'h00, 5'h00, 16'h00FF, 1, 0, 5'h08, 5'h08);
    go(`OP_AND, 0, 0, 16'h00F0, 16'h003C, 8'h00, 5'h03, 16'h0030, 1, 0, 5'h01, 5'h0F);
    go(`OP_OR, 0, 1, 16'h00F0, 16'h0000, 8'h3C, 5'h00, 16'h00FC, 1, 0, 5'h08, 5'h0F);
    go(`OP_XOR, 0, 1, 16'h00F0, 16'h0000, 8'h3C, 5'h00, 16'h00CC, 1, 0, 5'h08, 5'h0F);
    go(`OP_NOT, 0, 0, 16'h005A, 16'h0000, 8'h00, 5'h00, 16'h00A5, 1, 0, 5'h08, 5'h0E);
    go(`OP_ASHL, 0, 0, 16'h5581, 16'h0000, 8'h00, 5'h00, 16'h5502, 1, 0, 5'h03, 5'h03);
    go(`OP_ASHR, 0, 0, 16'h5581, 16'h0000, 8'h00, 5'h00, 16'h55C0, 1, 0, 5'h01, 5'h03);
    go(`OP_LSHL, 0, 0, 16'h5581, 16'h0000, 8'h00, 5'h00, 16'h5502, 1, 0, 5'h01, 5'h03);
    go(`OP_LSHR, 0, 0, 16'h5581, 16'h0000, 8'h00, 5'h00, 16'h5540, 1, 0, 5'h01, 5'h03);
    go(`OP_ROTATE_LEFT, 0, 0, 16'h5581, 16'h0000, 8'h00, 5'h00, 16'h5503, 1, 0, 5'h01, 5'h03);
    go(`OP_ROTATE_RIGHT, 0, 0, 16'h5581, 16'h0000, 8'h00, 5'h00, 16'h55C0, 1, 0, 5'h01, 5'h03);
    go(`OP_ROTCL, 0, 0, 16'h5581, 16'h0000, 8'h00, 5'h00, 16'h5502, 1, 0, 5'h01, 5'h01);
    go(`OP_ROTCR, 0, 0, 16'h5581, 16'h0000, 8'h00, 5'h01, 16'h55C0, 1, 0, 5'h01, 5'h01);
    close_out();
  end
endmodule // arith_logic_shift_unit_tb
`default_nettype wire
